// ### rtl/scbs_pkg.sv
package scbs_pkg;

  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_DEVICE_ADDR = 8'h01;
  localparam logic [7:0] REG_SPARE = 8'h02;

  localparam int CFG_OVERRIDE_BIT = 0;
  localparam int CFG_MODE_LSB = 2;
  localparam int DEVADDR_SRC_BIT = 7;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] DEVADDR_RESET_SER = 8'h68;
  localparam logic [7:0] DEVADDR_RESET_DES = 8'h70;
  localparam logic [7:0] SPARE_RESET = 8'h00;

  // Decoded divider level: 0 -> 0.47k, 1 -> 2.7k, 2 -> 8.2k, 3 -> open
  localparam logic [6:0] ADDR_SER_R047 = 7'h69;
  localparam logic [6:0] ADDR_SER_R27 = 7'h6a;
  localparam logic [6:0] ADDR_SER_R82 = 7'h6b;
  localparam logic [6:0] ADDR_SER_OPEN = 7'h6e;
  localparam logic [6:0] ADDR_DES_R047 = 7'h71;
  localparam logic [6:0] ADDR_DES_R27 = 7'h72;
  localparam logic [6:0] ADDR_DES_R82 = 7'h73;
  localparam logic [6:0] ADDR_DES_OPEN = 7'h76;

  localparam int POWERUP_MS = 10;
  localparam int CLOCK_HZ = 40000000;
  localparam int POWERUP_CYCLES = POWERUP_MS * (CLOCK_HZ / 1000);
  localparam int FILTER_MIN_PERIODS = 3;

  typedef enum logic [1:0] {
    MODE_NORMAL_NOFILT = 2'h0,
    MODE_NORMAL_FILT = 2'h1,
    MODE_COMPAT_GEN2 = 2'h2,
    MODE_COMPAT_GEN1 = 2'h3
  } scbs_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_MACK = 3'h6
  } scbs_state_t;

  typedef struct packed {
    logic from_regs;
    scbs_mode_t mode;
    logic filter_en;
    logic compat_gen2;
    logic compat_gen1;
  } scbs_cfg_t;

endpackage

// ### rtl/scbs_serial_control_slave.sv
`timescale 1ns/10ps
module scbs_serial_control_slave #(
  parameter bit IS_DESERIALIZER = 1'b0,
  parameter int POWERUP_CYCLES = scbs_pkg::POWERUP_CYCLES,
  parameter int CTRL_WIDTH = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic link_clock,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] address_select_pin,
  input wire logic [1:0] mode_pins,
  input wire logic [CTRL_WIDTH-1:0] ctrl_in,
  output logic [CTRL_WIDTH-1:0] ctrl_out,
  output scbs_pkg::scbs_cfg_t cfg,
  output logic [6:0] dev_addr,
  output logic bus_ready
);

  localparam int PW = $clog2(POWERUP_CYCLES + 1);

  if (POWERUP_CYCLES < 1 || CTRL_WIDTH < 1) begin : g_bad_params
    $error("scbs: POWERUP_CYCLES and CTRL_WIDTH must be at least one");
  end

  // Four strap levels map to four addresses per role
  function automatic logic [6:0] pin_address(input logic des,
                                             input logic [1:0] lvl);
    logic [6:0] a;
    a = 7'h00;
    unique case (lvl)
      2'h0: a = des ? scbs_pkg::ADDR_DES_R047 : scbs_pkg::ADDR_SER_R047;
      2'h1: a = des ? scbs_pkg::ADDR_DES_R27 : scbs_pkg::ADDR_SER_R27;
      2'h2: a = des ? scbs_pkg::ADDR_DES_R82 : scbs_pkg::ADDR_SER_R82;
      2'h3: a = des ? scbs_pkg::ADDR_DES_OPEN : scbs_pkg::ADDR_SER_OPEN;
    endcase
    return a;
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                          input logic [7:0] c,
                                          input logic [7:0] d,
                                          input logic [7:0] s);
    logic [7:0] v;
    v = 8'h00;
    if (idx == scbs_pkg::REG_CONFIG) begin
      v = c;
    end else if (idx == scbs_pkg::REG_DEVICE_ADDR) begin
      v = d;
    end else if (idx == scbs_pkg::REG_SPARE) begin
      v = s;
    end
    return v;
  endfunction

  // Pin synchronisers; the third stage only serves edge detection
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic [1:0] lvl_s1_ff, lvl_s2_ff;
  logic [1:0] mode_s1_ff, mode_s2_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
      lvl_s1_ff <= 2'h3;
      lvl_s2_ff <= 2'h3;
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
      lvl_s1_ff <= address_select_pin;
      lvl_s2_ff <= lvl_s1_ff;
      mode_s1_ff <= mode_pins;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall = ~scl_s2_ff & scl_s3_ff;
  assign start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign stop_det = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

  // Power-up quiet time counted from reset release
  logic [PW-1:0] pwr_cnt_ff;
  logic bus_ready_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_cnt_ff <= '0;
      bus_ready_ff <= 1'b0;
    end else if (!bus_ready_ff) begin
      pwr_cnt_ff <= PW'(pwr_cnt_ff + 1'b1);
      bus_ready_ff <= (pwr_cnt_ff == PW'(POWERUP_CYCLES - 1));
    end
  end

  // Register file
  logic [7:0] config_ff, devaddr_ff, spare_ff;
  logic [7:0] ptr_ff, shift_ff;
  logic wr_en;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      config_ff <= scbs_pkg::CONFIG_RESET;
      devaddr_ff <= IS_DESERIALIZER ? scbs_pkg::DEVADDR_RESET_DES
                                    : scbs_pkg::DEVADDR_RESET_SER;
      spare_ff <= scbs_pkg::SPARE_RESET;
    end else if (wr_en) begin
      if (ptr_ff == scbs_pkg::REG_CONFIG) begin
        config_ff <= shift_ff;
      end
      if (ptr_ff == scbs_pkg::REG_DEVICE_ADDR) begin
        devaddr_ff <= shift_ff;
      end
      if (ptr_ff == scbs_pkg::REG_SPARE) begin
        spare_ff <= shift_ff;
      end
    end
  end

  // Own address: the override bit never touches it, only its own source bit
  logic [6:0] dev_addr_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dev_addr_ff <= 7'h00;
    end else if (devaddr_ff[scbs_pkg::DEVADDR_SRC_BIT]) begin
      dev_addr_ff <= devaddr_ff[6:0];
    end else begin
      dev_addr_ff <= pin_address(IS_DESERIALIZER, lvl_s2_ff);
    end
  end

  // Effective configuration
  scbs_pkg::scbs_cfg_t cfg_ff;
  scbs_pkg::scbs_mode_t eff_mode;
  logic from_regs;
  assign from_regs = config_ff[scbs_pkg::CFG_OVERRIDE_BIT];
  assign eff_mode = from_regs
    ? scbs_pkg::scbs_mode_t'(config_ff[scbs_pkg::CFG_MODE_LSB +: 2])
    : scbs_pkg::scbs_mode_t'(mode_s2_ff);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.from_regs <= from_regs;
      cfg_ff.mode <= eff_mode;
      cfg_ff.filter_en <= (eff_mode == scbs_pkg::MODE_NORMAL_FILT);
      cfg_ff.compat_gen2 <= (eff_mode == scbs_pkg::MODE_COMPAT_GEN2);
      cfg_ff.compat_gen1 <= (eff_mode == scbs_pkg::MODE_COMPAT_GEN1);
    end
  end

  // Bus protocol engine
  scbs_pkg::scbs_state_t state_ff;
  logic [3:0] cnt_ff;
  logic rw_ff, first_ff, have_ptr_ff, mack_ff, sda_oe_ff, sda_o_ff;
  logic byte_end, addr_match;
  logic [7:0] rd_byte;

  assign byte_end = (state_ff == scbs_pkg::ST_RX) && scl_fall
                    && (cnt_ff == 4'h8) && !stop_det;
  assign addr_match = (shift_ff[7:1] == dev_addr_ff);
  assign wr_en = byte_end && !first_ff && have_ptr_ff;
  assign rd_byte = reg_read(ptr_ff, config_ff, devaddr_ff, spare_ff);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= scbs_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      have_ptr_ff <= 1'b0;
      mack_ff <= 1'b0;
      ptr_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
    end else if (!bus_ready_ff) begin
      state_ff <= scbs_pkg::ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= scbs_pkg::ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= scbs_pkg::ST_RX;
      cnt_ff <= 4'h0;
      first_ff <= 1'b1;
      have_ptr_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        scbs_pkg::ST_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        scbs_pkg::ST_RX: begin
          if (scl_rise && cnt_ff != 4'h8) begin
            shift_ff <= {shift_ff[6:0], sda_s2_ff};
            cnt_ff <= 4'(cnt_ff + 1'b1);
          end else if (byte_end) begin
            if (first_ff) begin
              first_ff <= 1'b0;
              rw_ff <= shift_ff[0];
              // Mismatch simply releases the line, pull-up gives the NACK
              state_ff <= addr_match ? scbs_pkg::ST_ACK
                                     : scbs_pkg::ST_IDLE;
              sda_oe_ff <= addr_match;
            end else begin
              if (!have_ptr_ff) begin
                ptr_ff <= shift_ff;
                have_ptr_ff <= 1'b1;
              end else begin
                ptr_ff <= 8'(ptr_ff + 1'b1);
              end
              state_ff <= scbs_pkg::ST_ACK;
              sda_oe_ff <= 1'b1;
            end
          end
        end
        scbs_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              state_ff <= scbs_pkg::ST_TX;
              sda_oe_ff <= ~rd_byte[7];
              shift_ff <= {rd_byte[6:0], 1'b0};
              ptr_ff <= 8'(ptr_ff + 1'b1);
              cnt_ff <= 4'h1;
            end else begin
              state_ff <= scbs_pkg::ST_RX;
              sda_oe_ff <= 1'b0;
              cnt_ff <= 4'h0;
            end
          end
        end
        scbs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == 4'h8) begin
              state_ff <= scbs_pkg::ST_MACK;
              sda_oe_ff <= 1'b0;
            end else begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff <= {shift_ff[6:0], 1'b0};
              cnt_ff <= 4'(cnt_ff + 1'b1);
            end
          end
        end
        scbs_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s2_ff;
          end else if (scl_fall) begin
            if (mack_ff) begin
              state_ff <= scbs_pkg::ST_TX;
              sda_oe_ff <= ~rd_byte[7];
              shift_ff <= {rd_byte[6:0], 1'b0};
              ptr_ff <= 8'(ptr_ff + 1'b1);
              cnt_ff <= 4'h1;
            end else begin
              state_ff <= scbs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= scbs_pkg::ST_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // Data pin only ever pulls low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sda_o_ff <= 1'b0;
    end else begin
      sda_o_ff <= 1'b0;
    end
  end

  // Link domain: reset with synchronous release, filter enable crossing
  logic lrst_s1_ff, lrst_n_ff;
  logic fen_s1_ff, fen_s2_ff;
  logic [CTRL_WIDTH-1:0] last_ff, ctrl_out_ff;
  logic [1:0] stable_ff;

  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      lrst_s1_ff <= 1'b0;
      lrst_n_ff <= 1'b0;
    end else begin
      lrst_s1_ff <= 1'b1;
      lrst_n_ff <= lrst_s1_ff;
    end
  end

  always_ff @(posedge link_clock or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      fen_s1_ff <= 1'b0;
      fen_s2_ff <= 1'b0;
    end else begin
      fen_s1_ff <= cfg_ff.filter_en;
      fen_s2_ff <= fen_s1_ff;
    end
  end

  // A level passes only once seen on three consecutive link edges
  always_ff @(posedge link_clock or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      last_ff <= '0;
      stable_ff <= 2'h0;
      ctrl_out_ff <= '0;
    end else begin
      last_ff <= ctrl_in;
      if (ctrl_in != last_ff) begin
        stable_ff <= 2'h0;
      end else if (stable_ff != 2'h2) begin
        stable_ff <= 2'(stable_ff + 1'b1);
      end
      if (!fen_s2_ff) begin
        ctrl_out_ff <= ctrl_in;
      end else if (ctrl_in == last_ff && stable_ff != 2'h0) begin
        ctrl_out_ff <= ctrl_in;
      end
    end
  end

  assign sda_o = sda_o_ff;
  assign sda_oe = sda_oe_ff;
  assign ctrl_out = ctrl_out_ff;
  assign cfg = cfg_ff;
  assign dev_addr = dev_addr_ff;
  assign bus_ready = bus_ready_ff;

  a_quiet_powerup: assert property (@(posedge clock) disable iff (!resetn)
    !bus_ready_ff |-> !sda_oe_ff)
    else $error("data line driven before power-up delay");

  a_ready_timing: assert property (@(posedge clock) disable iff (!resetn)
    $rose(bus_ready_ff) |-> $past(pwr_cnt_ff) == PW'(POWERUP_CYCLES - 1))
    else $error("bus ready at wrong count");

  a_stop_release: assert property (@(posedge clock) disable iff (!resetn)
    bus_ready_ff && stop_det |=> state_ff == scbs_pkg::ST_IDLE && !sda_oe_ff)
    else $error("stop did not end transaction");

  a_start_receive: assert property (@(posedge clock) disable iff (!resetn)
    bus_ready_ff && start_det && !stop_det
    |=> state_ff == scbs_pkg::ST_RX && cnt_ff == 4'h0 && first_ff)
    else $error("start not taken");

  a_ack_match: assert property (@(posedge clock) disable iff (!resetn)
    bus_ready_ff && !start_det && byte_end && first_ff && addr_match
    |=> sda_oe_ff && state_ff == scbs_pkg::ST_ACK)
    else $error("matching address not acknowledged");

  a_nack_mismatch: assert property (@(posedge clock) disable iff (!resetn)
    bus_ready_ff && !start_det && byte_end && first_ff && !addr_match
    |=> !sda_oe_ff [*2])
    else $error("mismatched address drove data line");

  a_write_ack: assert property (@(posedge clock) disable iff (!resetn)
    bus_ready_ff && !start_det && wr_en |=> sda_oe_ff && state_ff == scbs_pkg::ST_ACK)
    else $error("written byte not acknowledged");

  a_pin_mode: assert property (@(posedge clock) disable iff (!resetn)
    !from_regs |=> cfg_ff.mode == $past(mode_s2_ff) && !cfg_ff.from_regs)
    else $error("pins ignored without override");

  a_reg_mode: assert property (@(posedge clock) disable iff (!resetn)
    from_regs |=> cfg_ff.mode == $past(config_ff[3:2]))
    else $error("register mode not applied under override");

  a_mode_decode: assert property (@(posedge clock) disable iff (!resetn)
    cfg_ff.filter_en == (cfg_ff.mode == scbs_pkg::MODE_NORMAL_FILT)
    && cfg_ff.compat_gen2 == (cfg_ff.mode == scbs_pkg::MODE_COMPAT_GEN2)
    && cfg_ff.compat_gen1 == (cfg_ff.mode == scbs_pkg::MODE_COMPAT_GEN1))
    else $error("mode decode wrong");

  a_addr_source: assert property (@(posedge clock) disable iff (!resetn)
    devaddr_ff[7] |=> dev_addr_ff == $past(devaddr_ff[6:0]))
    else $error("register address not used");

  a_filter_width: assert property (@(posedge link_clock) disable iff (!lrst_n_ff)
    $past(fen_s2_ff) && ctrl_out_ff != $past(ctrl_out_ff)
    |-> $past(ctrl_in) == $past(ctrl_in, 2) && $past(ctrl_in, 2) == $past(ctrl_in, 3))
    else $error("short control pulse passed the filter");

endmodule // scbs_serial_control_slave

// ### test/scbs_host_model.sv
`timescale 1ns/10ps
module scbs_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_oe,
  output logic res_stb,
  output logic [8:0] res
);
  // Each bus phase lasts well beyond the device's two-flop synchronisers
  localparam int QTR = 4;

  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    res_stb = 1'b0;
    res = 9'h000;
  end

  task automatic wait_q(input int n);
    repeat (n * QTR) @(posedge clock);
  endtask

  task automatic post(input logic kind, input logic [7:0] v);
    res <= {kind, v};
    res_stb <= 1'b1;
    @(posedge clock);
    res_stb <= 1'b0;
  endtask

  // Also serves as repeated start when the clock line is low
  task automatic start_cond();
    sda_oe <= 1'b0;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_oe <= 1'b1;
    wait_q(1);
    scl <= 1'b0;
    wait_q(1);
  endtask

  task automatic stop_cond();
    sda_oe <= 1'b1;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_oe <= 1'b0;
    wait_q(2);
  endtask

  task automatic put_bit(input logic b);
    sda_oe <= ~b;
    wait_q(1);
    scl <= 1'b1;
    wait_q(2);
    scl <= 1'b0;
    wait_q(1);
  endtask

  task automatic get_bit(output logic b);
    sda_oe <= 1'b0;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    b = sda;
    wait_q(1);
    scl <= 1'b0;
    wait_q(1);
  endtask

  task automatic send_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    post(1'b0, {7'h00, a});
  endtask

  task automatic recv_byte(input logic more);
    logic [7:0] d;
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(~more);
    post(1'b1, d);
  endtask
endmodule // scbs_host_model

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [6:0] SER_TAB [4] = '{7'h69, 7'h6a, 7'h6b, 7'h6e};
  localparam logic [6:0] DES_TAB [4] = '{7'h71, 7'h72, 7'h73, 7'h76};
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] address_select_pin = 2'h0;
  logic [1:0] mode_pins = 2'h0;
  logic [2:0] ctrl_in = 3'h0;
  localparam int QUIET = 400;
  logic [2:0] ctrl_out, des_ctrl;
  logic scl, sda, host_oe, dut_o, dut_oe, des_o, des_oe, bus_ready, res_stb;
  logic des_ready;
  logic [8:0] res, e_n;
  logic [6:0] dev_addr, des_addr;
  scbs_pkg::scbs_cfg_t cfg, des_cfg;
  logic [8:0] exp_q[$];
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] r;

  initial forever #12.5 clock = ~clock;
  initial begin
    #3;
    forever #7.5 link_clock = ~link_clock;
  end
  // Released lines float to the pull-up level
  assign sda = (~dut_oe | dut_o) & (~des_oe | des_o) & ~host_oe;

  scbs_host_model host (.clock(clock), .sda(sda), .scl(scl),
    .sda_oe(host_oe), .res_stb(res_stb), .res(res));
  scbs_serial_control_slave #(.POWERUP_CYCLES(QUIET))
    dut (.clock(clock), .resetn(resetn), .link_clock(link_clock),
    .scl_i(scl), .sda_i(sda), .sda_o(dut_o), .sda_oe(dut_oe),
    .address_select_pin(address_select_pin), .mode_pins(mode_pins),
    .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .cfg(cfg),
    .dev_addr(dev_addr), .bus_ready(bus_ready));
  scbs_serial_control_slave #(.IS_DESERIALIZER(1'b1), .POWERUP_CYCLES(QUIET))
    des (.clock(clock), .resetn(resetn), .link_clock(link_clock),
    .scl_i(scl), .sda_i(sda), .sda_o(des_o), .sda_oe(des_oe),
    .address_select_pin(address_select_pin), .mode_pins(mode_pins),
    .ctrl_in(ctrl_in), .ctrl_out(des_ctrl), .cfg(des_cfg),
    .dev_addr(des_addr), .bus_ready(des_ready));

  task automatic check_bit(input string n, input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask

  task automatic check_byte(input string n, input logic [7:0] e,
                            input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_cfg(input logic f, input logic [1:0] m);
    return {2'b00, f, m, m == 2'h1, m == 2'h2, m == 2'h3};
  endfunction

  // A low acknowledge bit means acknowledged
  task automatic addr_phase(input logic [6:0] a, input logic rd,
                            input logic ack);
    exp_q.push_back({1'b0, 7'h00, ~ack});
    host.start_cond();
    host.send_byte({a, rd});
  endtask

  task automatic data_out(input logic [7:0] d, input logic ack);
    exp_q.push_back({1'b0, 7'h00, ~ack});
    host.send_byte(d);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] idx,
                    input logic [7:0] d);
    addr_phase(a, 1'b0, 1'b1);
    data_out(idx, 1'b1);
    data_out(d, 1'b1);
    host.stop_cond();
  endtask

  task automatic rd2(input logic [6:0] a, input logic [7:0] idx,
                     input logic [7:0] e0, input logic [7:0] e1);
    addr_phase(a, 1'b0, 1'b1);
    data_out(idx, 1'b1);
    addr_phase(a, 1'b1, 1'b1);
    exp_q.push_back({1'b1, e0});
    host.recv_byte(1'b1);
    exp_q.push_back({1'b1, e1});
    host.recv_byte(1'b0);
    host.stop_cond();
  endtask

  always @(posedge clock) begin
    if (res_stb === 1'b1 && exp_q.size() == 0) begin
      check_bit("extra_result", 1'b0, res_stb);
    end else if (res_stb === 1'b1) begin
      e_n = exp_q.pop_front();
      if (e_n[8]) check_byte("read_data", e_n[7:0], res[7:0]);
      else check_bit("ack_bit", e_n[0], res[0]);
    end
  end

  // Whole sequence needs roughly 8000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(29434));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check_bit("bus_ready", 1'b0, bus_ready);
    check_byte("cfg", 8'h00, {2'b00, cfg});
    addr_phase(SER_TAB[0], 1'b0, 1'b0);
    host.stop_cond();
    for (int i = 0; i < 1000 && bus_ready !== 1'b1; i++) @(posedge clock);
    check_bit("bus_ready", 1'b1, bus_ready);
    check_bit("des_ready", 1'b1, des_ready);
    // Decoded levels only: the select pin is never grounded
    for (int l = 0; l < 4; l++) begin
      address_select_pin <= 2'(l);
      repeat (8) @(posedge clock);
      check_byte("dev_addr", {1'b0, SER_TAB[l]}, {1'b0, dev_addr});
      check_byte("des_addr", {1'b0, DES_TAB[l]}, {1'b0, des_addr});
      addr_phase(SER_TAB[l] ^ 7'h01, 1'b0, 1'b0);
      host.stop_cond();
      addr_phase(SER_TAB[l], 1'b0, 1'b1);
      host.stop_cond();
    end
    address_select_pin <= 2'h0;
    for (int m = 0; m < 4; m++) begin
      mode_pins <= 2'(m);
      repeat (8) @(posedge clock);
      check_byte("cfg", exp_cfg(1'b0, 2'(m)), {2'b00, cfg});
      check_byte("des_cfg", exp_cfg(1'b0, 2'(m)), {2'b00, des_cfg});
    end
    for (int m = 0; m < 4; m++) begin
      wr(SER_TAB[0], 8'h00, {4'h0, 2'(m), 2'b01});
      repeat (4) @(posedge clock);
      check_byte("cfg", exp_cfg(1'b1, 2'(m)), {2'b00, cfg});
    end
    rd2(SER_TAB[0], 8'h00, 8'h0d, 8'h68);
    wr(SER_TAB[0], 8'h00, 8'h00);
    repeat (4) @(posedge clock);
    check_byte("cfg", exp_cfg(1'b0, 2'h3), {2'b00, cfg});
    r = 8'($urandom());
    addr_phase(SER_TAB[0], 1'b0, 1'b1);
    data_out(8'h01, 1'b1);
    data_out(8'hd5, 1'b1);
    data_out(r, 1'b1);
    host.stop_cond();
    addr_phase(SER_TAB[0], 1'b0, 1'b0);
    host.stop_cond();
    check_byte("dev_addr", 8'h55, {1'b0, dev_addr});
    rd2(7'h55, 8'h01, 8'hd5, r);
    rd2(7'h55, 8'h05, 8'h00, 8'h00);
    wr(7'h55, 8'h01, 8'h68);
    addr_phase(SER_TAB[0], 1'b0, 1'b1);
    host.stop_cond();
    check_byte("dev_addr", 8'h69, {1'b0, dev_addr});
    mode_pins <= 2'h1;
    repeat (8) @(posedge clock);
    r = 8'($urandom_range(1, 7));
    @(posedge link_clock);
    ctrl_in <= r[2:0];
    repeat (2) @(posedge link_clock);
    ctrl_in <= 3'h0;
    repeat (6) @(posedge link_clock);
    // Outputs are looked at mid-period, once the link edge has settled
    @(negedge link_clock);
    check_byte("ctrl_out", 8'h00, {5'h00, ctrl_out});
    @(posedge link_clock);
    ctrl_in <= r[2:0];
    repeat (2) @(posedge link_clock);
    @(negedge link_clock);
    check_byte("ctrl_out", 8'h00, {5'h00, ctrl_out});
    @(negedge link_clock);
    check_byte("ctrl_out", {5'h00, r[2:0]}, {5'h00, ctrl_out});
    check_byte("des_ctrl", {5'h00, r[2:0]}, {5'h00, des_ctrl});
    @(posedge clock);
    mode_pins <= 2'h0;
    repeat (8) @(posedge clock);
    @(posedge link_clock);
    ctrl_in <= ~r[2:0];
    // Filter off: a level passes after a single link edge
    @(posedge link_clock);
    @(negedge link_clock);
    check_byte("ctrl_out", {5'h00, ~r[2:0]}, {5'h00, ctrl_out});
    check_byte("des_ctrl", {5'h00, ~r[2:0]}, {5'h00, des_ctrl});
    check_byte("pending", 8'h00, 8'(exp_q.size()));
    complete_run();
  end
endmodule // testbench
